// >>> phec_defs.svh
// Constants for the PHY error-count and control register bank.
// Assumes a 250 MHz device clock and 5-bit management register addresses.
`ifndef PHEC_DEFS_SVH
`define PHEC_DEFS_SVH

// Register addresses
`define PHEC_REG_RXERR 5'h15
`define PHEC_REG_CTL 5'h17

// Control register fields
`define PHEC_BIT_SAT 13
`define PHEC_BIT_TXTRI 12
`define PHEC_BIT_IRQEN 11
`define PHEC_BIT_PRESUP 10
`define PHEC_BIT_SPEED 9
`define PHEC_BIT_DUPLEX 8
`define PHEC_BIT_ACTBOTH 7
`define PHEC_BIT_OFF_LO 1
`define PHEC_BIT_NOSTRETCH 0
`define PHEC_CTL_WMASK 16'h3cff

// Reset values
`define PHEC_CTL_RST 16'h0000
`define PHEC_CNT_RST 16'h0000
`define PHEC_CNT_MAX 16'hffff

// Timing
`define PHEC_CLK_HZ 250000000
`define PHEC_MS_PER_S 1000
`define PHEC_STRETCH_MIN_MS 48
`define PHEC_STRETCH_MAX_MS 72

`endif

// >>> phec_pkg.sv
// Types shared by the register bank modules.
// Assumes phec_defs.svh supplies the numeric constants.
package phec_pkg;
  typedef logic [15:0] phec_word_t;
  typedef enum logic [2:0] {
    PHEC_IND_SPEED = 3'h0,
    PHEC_IND_FDX = 3'h1,
    PHEC_IND_COL = 3'h2,
    PHEC_IND_LINK = 3'h3,
    PHEC_IND_TXACT = 3'h4,
    PHEC_IND_RX = 3'h5
  } phec_ind_e;
  localparam int PHEC_NUM_IND = 6;
endpackage

// >>> phec_cnt_if.sv
// Interface between the register bank and its event counter.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface phec_cnt_if #(parameter int W = 16);
  logic inc;
  logic clr;
  logic sat;
  logic [W-1:0] count;
  modport ctl (output inc, output clr, output sat, input count);
  modport cnt (input inc, input clr, input sat, output count);
endinterface
`default_nettype wire

// >>> phec_cnt.sv
// Event counter with clear, wrap or saturate at all ones.
// Assumes clear and increment are single-cycle strobes on mclk.
`timescale 1ns/1ns
`default_nettype none
module phec_cnt #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Counter port
  phec_cnt_if.cnt cif
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic [W-1:0] base;

  always_comb
  begin
    // Clear and event together leave a count of one
    base = cif.clr ? '0 : cnt_r;
    cnt_nxt = base;
    if (cif.inc)
    begin
      if (cif.sat && (&base))
        cnt_nxt = base;
      else
        cnt_nxt = base + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign cif.count = cnt_r;
endmodule // phec_cnt
`default_nettype wire

// >>> phec_stretch.sv
// Indicator pulse stretcher counting millisecond ticks.
// Assumes ms_tick is a one-cycle pulse once per millisecond.
`timescale 1ns/1ns
`default_nettype none
`include "phec_defs.svh"
module phec_stretch #(
  parameter int STRETCH_MS =
    (`PHEC_STRETCH_MIN_MS + `PHEC_STRETCH_MAX_MS) / 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic ms_tick,
  input wire logic stretch_dis,
  // Indicator
  input wire logic trig,
  output logic out_r
);
  logic [6:0] left_r;
  logic [6:0] left_nxt;
  logic out_nxt;

  always_comb
  begin
    left_nxt = left_r;
    if (trig)
      left_nxt = 7'(STRETCH_MS);
    else if (ms_tick && (left_r != 7'h00))
      left_nxt = left_r - 7'h01;
    // Hold-off after release lies between STRETCH_MS-1 and STRETCH_MS
    out_nxt = stretch_dis ? trig : (trig | (left_r != 7'h00));
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      left_r <= 7'h00;
      out_r <= 1'b0;
    end
    else
    begin
      left_r <= left_nxt;
      out_r <= out_nxt;
    end
  end
endmodule // phec_stretch
`default_nettype wire

// >>> phec_regs.sv
// Receive error counter and vendor control/status register bank.
// Assumes the device's management frame engine presents decoded
// register reads and writes as one-cycle strobes on mclk.
`timescale 1ns/1ns
`default_nettype none
`include "phec_defs.svh"
module phec_regs #(
  parameter int MS_CYCLES = `PHEC_CLK_HZ / `PHEC_MS_PER_S
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Management register access
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata_r,
  output logic mgmt_rvalid_r,
  // Receive datapath events
  input wire logic rx_pkt_active,
  input wire logic rx_err_sym,
  // Resolved link state
  input wire logic speed_100,
  input wire logic full_duplex,
  // Transmit pair tri-state pin
  input wire logic tx_pair_tristate_pin,
  // Controls to other device logic
  output logic counter_saturate_mode,
  output logic tx_pair_hiz_r,
  output logic mdio_irq_en,
  output logic preamble_supp_en,
  // Indicator activity sources
  input wire logic rx_activity,
  input wire logic tx_activity,
  input wire logic link_up,
  input wire logic collision,
  // Indicator pins
  output logic receive_indicator,
  output logic transmit_activity_indicator,
  output logic link_indicator,
  output logic collision_indicator,
  output logic full_duplex_indicator,
  output logic speed_indicator,
  output logic [5:0] indicator_oe_r
);
  localparam int NI = phec_pkg::PHEC_NUM_IND;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser for the transmit tri-state pin
  logic [2:0] pin_sync_r;
  logic [2:0] pin_sync_nxt;
  logic pin_lvl_r;
  logic pin_lvl_nxt;

  always_comb
  begin
    pin_sync_nxt = {pin_sync_r[1:0], tx_pair_tristate_pin};
    pin_lvl_nxt = pin_lvl_r;
    // A pin change counts once two stages agree
    if (pin_sync_r[1] == pin_sync_r[2])
      pin_lvl_nxt = pin_sync_r[2];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pin_sync_r <= 3'h0;
      pin_lvl_r <= 1'b0;
    end
    else
    begin
      pin_sync_r <= pin_sync_nxt;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider
  logic [17:0] div_r;
  logic [17:0] div_nxt;
  logic ms_tick_r;
  logic ms_tick_nxt;

  always_comb
  begin
    // One-cycle enable, no derived clock
    ms_tick_nxt = (div_r == 18'(MS_CYCLES - 1));
    div_nxt = ms_tick_nxt ? 18'h00000 : div_r + 18'h00001;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      div_r <= 18'h00000;
      ms_tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      ms_tick_r <= ms_tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-packet receive error detection
  logic pkt_act_r;
  logic pkt_act_nxt;
  logic err_seen_r;
  logic err_seen_nxt;
  logic pkt_err_end;

  always_comb
  begin
    pkt_act_nxt = rx_pkt_active;
    // One count when an errored packet ends, however many bad symbols
    pkt_err_end = pkt_act_r && !rx_pkt_active
      && (err_seen_r || rx_err_sym);
    // Flag is dropped between packets
    err_seen_nxt = err_seen_r;
    if (!rx_pkt_active)
      err_seen_nxt = 1'b0;
    else if (rx_err_sym)
      err_seen_nxt = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pkt_act_r <= 1'b0;
      err_seen_r <= 1'b0;
    end
    else
    begin
      pkt_act_r <= pkt_act_nxt;
      err_seen_r <= err_seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive error counter
  phec_cnt_if #(.W(16)) rxerr_if ();
  logic rd_rxerr;
  logic rd_ctl;
  logic wr_ctl;
  // Declared here because the counter reads the saturate bit
  phec_pkg::phec_word_t ctl_r;
  phec_pkg::phec_word_t ctl_nxt;

  // Writes to any other address are dropped; reads there return zero
  always_comb
  begin
    rd_rxerr = 1'b0;
    rd_ctl = 1'b0;
    wr_ctl = 1'b0;
    if (mgmt_addr == `PHEC_REG_RXERR)
      rd_rxerr = mgmt_rd;
    if (mgmt_addr == `PHEC_REG_CTL)
    begin
      rd_ctl = mgmt_rd;
      wr_ctl = mgmt_wr;
    end
  end

  // Clear on read; an increment in the same cycle still counts
  assign rxerr_if.inc = pkt_err_end;
  assign rxerr_if.clr = rd_rxerr;
  assign rxerr_if.sat = ctl_r[`PHEC_BIT_SAT];

  phec_cnt #(.W(16)) u_rxerr_cnt (
    .mclk (mclk),
    .sys_rst (sys_rst),
    .cif (rxerr_if.cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control register

  always_comb
  begin
    ctl_nxt = ctl_r;
    // Status and reserved bits never stored
    if (wr_ctl)
      ctl_nxt = mgmt_wdata & `PHEC_CTL_WMASK;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ctl_r <= `PHEC_CTL_RST;
    else
      ctl_r <= ctl_nxt;
  end

  // Same bit drives the external isolate and false carrier counters
  assign counter_saturate_mode = ctl_r[`PHEC_BIT_SAT];
  assign mdio_irq_en = ctl_r[`PHEC_BIT_IRQEN];
  assign preamble_supp_en = ctl_r[`PHEC_BIT_PRESUP];

  ////////////////////////////////////////////////////////////////////////
  // Read path
  phec_pkg::phec_word_t rdata_nxt;
  logic rvalid_nxt;
  phec_pkg::phec_word_t ctl_view;

  always_comb
  begin
    ctl_view = ctl_r & `PHEC_CTL_WMASK;
    ctl_view[`PHEC_BIT_SPEED] = speed_100;
    ctl_view[`PHEC_BIT_DUPLEX] = full_duplex;
    // Count is captured in the cycle that clears it
    rvalid_nxt = mgmt_rd;
    rdata_nxt = 16'h0000;
    if (rd_rxerr)
      rdata_nxt = rxerr_if.count;
    else if (rd_ctl)
      rdata_nxt = ctl_view;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mgmt_rdata_r <= 16'h0000;
      mgmt_rvalid_r <= 1'b0;
    end
    else
    begin
      mgmt_rdata_r <= rdata_nxt;
      mgmt_rvalid_r <= rvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit pair tri-state and indicator enables
  logic hiz_nxt;
  logic [5:0] oe_nxt;

  always_comb
  begin
    hiz_nxt = ctl_r[`PHEC_BIT_TXTRI] | pin_lvl_r;
    // Enable high while the pin is driven
    oe_nxt = ~ctl_r[`PHEC_BIT_OFF_LO +: 6];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tx_pair_hiz_r <= 1'b0;
      // Off bits reset clear, so every indicator starts driven
      indicator_oe_r <= 6'h3f;
    end
    else
    begin
      tx_pair_hiz_r <= hiz_nxt;
      indicator_oe_r <= oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Indicator stretchers
  logic [NI-1:0] ind_src;
  logic [NI-1:0] ind_out;

  always_comb
  begin
    ind_src = '0;
    ind_src[phec_pkg::PHEC_IND_SPEED] = speed_100;
    ind_src[phec_pkg::PHEC_IND_FDX] = full_duplex;
    ind_src[phec_pkg::PHEC_IND_COL] = collision;
    ind_src[phec_pkg::PHEC_IND_LINK] = link_up;
    ind_src[phec_pkg::PHEC_IND_TXACT] = tx_activity
      | (ctl_r[`PHEC_BIT_ACTBOTH] & rx_activity);
    ind_src[phec_pkg::PHEC_IND_RX] = rx_activity;
  end

  // One stretcher per pin so sources never hold each other lit, except rx_activity on the transmit pin while ACTBOTH is set
  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++)
    begin : g_ind
      phec_stretch u_stretch (
        .mclk (mclk),
        .sys_rst (sys_rst),
        .ms_tick (ms_tick_r),
        .stretch_dis (ctl_r[`PHEC_BIT_NOSTRETCH]),
        .trig (ind_src[gi]),
        .out_r (ind_out[gi])
      );
    end
  endgenerate

  assign speed_indicator = ind_out[phec_pkg::PHEC_IND_SPEED];
  assign full_duplex_indicator = ind_out[phec_pkg::PHEC_IND_FDX];
  assign collision_indicator = ind_out[phec_pkg::PHEC_IND_COL];
  assign link_indicator = ind_out[phec_pkg::PHEC_IND_LINK];
  assign transmit_activity_indicator = ind_out[phec_pkg::PHEC_IND_TXACT];
  assign receive_indicator = ind_out[phec_pkg::PHEC_IND_RX];
endmodule // phec_regs
`default_nettype wire

// >>> phec_regs_sva.sv
// Port checker for the register bank.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module phec_regs_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register access
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata_r,
  input wire logic mgmt_rvalid_r,
  // Status and controls
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic counter_saturate_mode,
  input wire logic tx_pair_hiz_r,
  input wire logic mdio_irq_en,
  input wire logic preamble_supp_en,
  input wire logic [5:0] indicator_oe_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic cw;
  assign cw = mgmt_wr && mgmt_addr == 5'h17;
  ////////////////////////////////////////////////////////////////////
  property p_rd_lat;
    mgmt_rd |=> mgmt_rvalid_r;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_rsv;
    mgmt_rvalid_r && $past(mgmt_addr) == 5'h17 |->
      mgmt_rdata_r[15:14] == 2'b00;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits set");
  property p_spd;
    mgmt_rvalid_r && $past(mgmt_addr) == 5'h17 |->
      mgmt_rdata_r[9] == $past(speed_100);
  endproperty
  a_spd: assert property (p_spd)
    else $error("speed bit wrong");
  property p_dpx;
    mgmt_rvalid_r && $past(mgmt_addr) == 5'h17 |->
      mgmt_rdata_r[8] == $past(full_duplex);
  endproperty
  a_dpx: assert property (p_dpx)
    else $error("duplex bit wrong");
  property p_sat;
    cw |=> counter_saturate_mode == $past(mgmt_wdata[13]);
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturate mode wrong");
  property p_irq;
    cw |=> mdio_irq_en == $past(mgmt_wdata[11]);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq enable wrong");
  property p_pre;
    cw |=> preamble_supp_en == $past(mgmt_wdata[10]);
  endproperty
  a_pre: assert property (p_pre)
    else $error("preamble enable wrong");
  property p_hiz;
    cw && mgmt_wdata[12] |=> ##1 tx_pair_hiz_r;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("transmitter not tri-stated");
  property p_oe;
    cw |-> ##2 indicator_oe_r == ~$past(mgmt_wdata[6:1], 2);
  endproperty
  a_oe: assert property (p_oe)
    else $error("indicator enable wrong");
  c_rd_cnt: cover property (mgmt_rd && mgmt_addr == 5'h15);
  c_cw: cover property (cw);
  c_hiz: cover property ($rose(tx_pair_hiz_r));
endmodule // phec_regs_sva
bind phec_regs phec_regs_sva u_sva (.*);
`default_nettype wire

// >>> phec_sta.sv
// Station management model issuing decoded register strobes.
// Assumes the bank answers reads one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module phec_sta (
  // Clock
  input wire logic mclk,
  // Register access
  output logic [4:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata_r,
  input wire logic mgmt_rvalid_r
);
  initial
  begin
    mgmt_addr = 5'h00;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  // Released lines show inverted values
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk) #1;
    mgmt_addr = a;
    mgmt_wdata = v;
    mgmt_wr = 1'b1;
    @(posedge mclk) #1;
    mgmt_wr = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~v;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge mclk) #1;
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(posedge mclk) #1;
    mgmt_rd = 1'b0;
    mgmt_addr = ~a;
    v = (mgmt_rvalid_r === 1'b1) ? mgmt_rdata_r : 16'hxxxx;
  endtask
endmodule // phec_sta
`default_nettype wire

// >>> test_phec_regs.sv
// Self-checking bench for the register bank.
// Assumes phec_sta for access and a shortened millisecond.
`timescale 1ns/1ns
`default_nettype none
module test_phec_regs;
  logic mclk, sys_rst, mgmt_wr, mgmt_rd, mgmt_rvalid_r;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata_r, d;
  logic rx_pkt_active, rx_err_sym, speed_100, full_duplex;
  logic tx_pair_tristate_pin, rx_activity, tx_activity, link_up;
  logic collision, counter_saturate_mode, tx_pair_hiz_r;
  logic mdio_irq_en, preamble_supp_en, receive_indicator;
  logic transmit_activity_indicator, link_indicator;
  logic collision_indicator, full_duplex_indicator, speed_indicator;
  logic [5:0] indicator_oe_r;
  int n_mismatch, n_tests;
  phec_regs #(.MS_CYCLES(10)) uut (.*);
  phec_sta sta (.*);
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Packet with two separate errored symbols when e is set
  task automatic pkt(input logic e);
    rx_pkt_active = 1'b1;
    rx_err_sym = e;
    cyc(1);
    rx_err_sym = 1'b0;
    cyc(1);
    rx_err_sym = e;
    cyc(1);
    rx_err_sym = 1'b0;
    rx_pkt_active = 1'b0;
    cyc(2);
  endtask
  task tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    {rx_pkt_active, rx_err_sym, speed_100, full_duplex} = 4'h0;
    {tx_pair_tristate_pin, rx_activity, tx_activity} = 3'h0;
    {link_up, collision} = 2'h0;
    n_mismatch = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    cyc(10);
    sys_rst = 1'b0;
    sta.rd(5'h17, d);
    chk(d, 16'h0000);
    sta.rd(5'h15, d);
    chk(d, 16'h0000);
    sta.wr(5'h17, 16'hffff);
    sta.rd(5'h17, d);
    chk(d, 16'h3cff);
    chk({12'h000, counter_saturate_mode, mdio_irq_en, preamble_supp_en,
      tx_pair_hiz_r}, 16'h000f);
    chk({10'h000, indicator_oe_r}, 16'h0000);
    speed_100 = 1'b1;
    full_duplex = 1'b1;
    sta.rd(5'h17, d);
    chk(d, 16'h3fff);
    sta.wr(5'h15, 16'hffff);
    sta.wr(5'h01, 16'hffff);
    sta.rd(5'h15, d);
    chk(d, 16'h0000);
    sta.rd(5'h01, d);
    chk(d, 16'h0000);
    pkt(1'b1);
    pkt(1'b0);
    pkt(1'b1);
    sta.rd(5'h15, d);
    chk(d, 16'h0002);
    sta.rd(5'h15, d);
    chk(d, 16'h0000);
    sta.wr(5'h17, 16'h0001);
    cyc(1);
    chk({15'h0000, tx_pair_hiz_r}, 16'h0000);
    chk({10'h000, indicator_oe_r}, 16'h003f);
    tx_pair_tristate_pin = 1'b1;
    cyc(6);
    chk({15'h0000, tx_pair_hiz_r}, 16'h0001);
    tx_pair_tristate_pin = 1'b0;
    cyc(6);
    chk({15'h0000, tx_pair_hiz_r}, 16'h0000);
    rx_activity = 1'b1;
    collision = 1'b1;
    cyc(2);
    chk({14'h0000, receive_indicator, transmit_activity_indicator},
      16'h0002);
    chk({13'h0000, collision_indicator, full_duplex_indicator,
      speed_indicator}, 16'h0007);
    sta.wr(5'h17, 16'h0081);
    cyc(1);
    chk({15'h0000, transmit_activity_indicator}, 16'h0001);
    rx_activity = 1'b0;
    collision = 1'b0;
    cyc(2);
    chk({15'h0000, transmit_activity_indicator}, 16'h0000);
    tx_activity = 1'b1;
    cyc(2);
    chk({15'h0000, transmit_activity_indicator}, 16'h0001);
    tx_activity = 1'b0;
    sta.wr(5'h17, 16'h0000);
    link_up = 1'b1;
    cyc(2);
    link_up = 1'b0;
    cyc(470);
    chk({15'h0000, link_indicator}, 16'h0001);
    cyc(260);
    chk({15'h0000, link_indicator}, 16'h0000);
    speed_100 = 1'b0;
    full_duplex = 1'b0;
    sta.wr(5'h17, 16'h3cff);
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    sta.rd(5'h17, d);
    chk(d, 16'h0000);
    tally_and_finish;
  end
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule // test_phec_regs
`default_nettype wire
